//--- logic/adc_mux_pkg.sv
// Purpose: shared constants and types for the converter mux and start control
// Assumes: AHB-Lite word access, register index times four is the byte address
// Notes: register indices kept as printed, byte addresses derived
package adc_mux_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] input_config_index = 8'h10;
  localparam logic [7:0] mux_control_index = 8'h12;
  localparam logic [31:0] input_config_addr = {22'h0, input_config_index, 2'h0};
  localparam logic [31:0] mux_control_addr = {22'h0, mux_control_index, 2'h0};
  localparam logic [7:0] reg_reset_value = 8'h00;

  // ==========================================================
  // mux control fields
  localparam int channel_lsb = 0;
  localparam int channel_msb = 4;
  localparam int single_bit = 5;
  localparam int continuous_bit = 6;
  localparam logic [7:0] mux_control_mask = 8'h7F;

  // ==========================================================
  // external input config fields
  localparam int absolute_lsb = 0;
  localparam int temp3_bit = 4;
  localparam int temp4_bit = 5;
  localparam int neg_switch_bit = 6;
  localparam int pos_switch_bit = 7;

  // ==========================================================
  // channel codes
  localparam logic [4:0] ch_input_last = 5'h03;
  localparam logic [4:0] ch_bridge_first = 5'h04;
  localparam logic [4:0] ch_switch_last = 5'h0F;
  localparam logic [4:0] ch_main_supply = 5'h10;
  localparam logic [4:0] ch_int_temp = 5'h11;
  localparam logic [4:0] ch_mirror = 5'h12;
  localparam logic [4:0] ch_diag_ratio_a = 5'h19;
  localparam logic [4:0] ch_diag_ratio_b = 5'h1A;
  localparam logic [4:0] ch_diag_abs = 5'h1B;
  localparam logic [4:0] ch_diag_vref = 5'h1C;
  localparam logic [4:0] ch_low_regulator = 5'h1D;
  localparam logic [4:0] ch_high_regulator = 5'h1E;
  localparam logic [4:0] ch_current_mux = 5'h1F;
  localparam logic [4:0] ch_input_three = 5'h02;
  localparam logic [4:0] ch_input_four = 5'h03;

  // ==========================================================
  // AHB encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq = 2'h3;

  typedef enum logic [2:0] {
    meas_ratiometric = 3'b000,
    meas_abs_voltage = 3'b001,
    meas_current = 3'b010,
    meas_ext_temp = 3'b011,
    meas_int_temp = 3'b100,
    meas_none = 3'b111
  } meas_kind_t;

  typedef enum logic [1:0] {
    ref_sensor_pins = 2'b00,
    ref_internal_voltage = 2'b01,
    ref_internal_current = 2'b10,
    ref_off = 2'b11
  } ref_sel_t;

  typedef enum logic [1:0] {
    conv_idle = 2'b00,
    conv_launch = 2'b01,
    conv_running = 2'b10
  } conv_state_t;

endpackage

//--- logic/adc_channel_decode.sv
// Purpose: decode a channel code into measurement kind and reference
// Assumes: config byte holds an absolute bit per input and temperature bits for inputs three and four only
// Notes: purely combinational
`timescale 1ns/1ps
module adc_channel_decode
  import adc_mux_pkg::*;
(
  // selection
  input wire logic [4:0] channel,
  input wire logic [7:0] input_config,
  // decoded path
  output meas_kind_t kind,
  output ref_sel_t ref_sel
);

  logic abs_bit;

  always_comb begin
    abs_bit = input_config[absolute_lsb + int'(channel[1:0])];
    kind = meas_none;
    ref_sel = ref_off;
    if (channel <= ch_input_last) begin
      // external inputs, temperature overrides absolute bit
      if ((channel == ch_input_three && input_config[temp3_bit]) ||
          (channel == ch_input_four && input_config[temp4_bit])) begin
        kind = meas_ext_temp;
        ref_sel = ref_internal_voltage;
      end else if (abs_bit) begin
        kind = meas_abs_voltage;
        ref_sel = ref_internal_voltage;
      end else begin
        kind = meas_ratiometric;
        ref_sel = ref_sensor_pins;
      end
    end else if (channel >= ch_bridge_first && channel <= ch_switch_last) begin
      kind = meas_current;
      ref_sel = ref_internal_current;
    end else if (channel == ch_main_supply || channel == ch_mirror) begin
      kind = meas_abs_voltage;
      ref_sel = ref_internal_voltage;
    end else if (channel == ch_int_temp) begin
      kind = meas_int_temp;
      ref_sel = ref_internal_voltage;
    end else if (channel == ch_diag_ratio_a || channel == ch_diag_ratio_b) begin
      kind = meas_ratiometric;
      ref_sel = ref_sensor_pins;
    end else if (channel == ch_current_mux) begin
      kind = meas_current;
      ref_sel = ref_internal_current;
    end else if (channel >= ch_diag_abs) begin
      kind = meas_abs_voltage;
      ref_sel = ref_internal_voltage;
    end
  end

endmodule // adc_channel_decode

//--- logic/adc_mux_control.sv
// Purpose: converter input mux selection and conversion start sequencing
// Assumes: conversion core outside pulses conv_done once per conversion
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Contract
// - channel select is mux control bits 4:0
// - reference path follows channel automatically
// - start runs sequence for selected kind
// - single request starts one, self clears
// - continuous enable repeats conversions back to back
// - both bits set means continuous mode
// - channel writes ignored while converting
// - bit 7 reads zero, writes ignored
// - codes 0-3 select external inputs
// - codes 4-11 select bridge currents alternating
// - codes 12-15 select high switch currents
// - code 16 selects main supply pin
// - 17 internal temperature, 18 mirror pin
// - codes 25-31 select diagnostic sources
// - absolute bit one absolute, zero ratiometric
// - temperature enable overrides absolute bit
// - input config read-only while converting
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module adc_mux_control
  import adc_mux_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // conversion core
  input wire logic conv_done,
  output logic conv_start,
  output logic conv_busy,
  output logic [4:0] channel_select,
  output meas_kind_t meas_kind,
  output ref_sel_t ref_sel,
  // analog switches
  output logic [1:0] input_temperature_enable,
  output logic pos_supply_switch,
  output logic neg_supply_switch
);

  // ==========================================================
  // bus address phase capture
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_index_q, wr_index_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic take;

  // ==========================================================
  // register and sequencer state
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cfg_q, cfg_d;
  conv_state_t state_q, state_d;
  logic start_q, start_d;
  logic busy_q, busy_d;
  meas_kind_t kind_q, kind_d;
  ref_sel_t ref_q, ref_d;
  meas_kind_t kind_c;
  ref_sel_t ref_c;
  logic [1:0] temp_en_q, temp_en_d;
  logic pos_sw_q, pos_sw_d;
  logic neg_sw_q, neg_sw_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q, hresp_d;

  function automatic logic [7:0] addr_index(input logic [31:0] a);
    addr_index = a[9:2];
  endfunction

  assign take = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);

  always_comb begin
    wr_pend_d = take && hwrite;
    wr_index_d = take ? addr_index(haddr) : wr_index_q;
    hrdata_d = 32'h0000_0000;
    // read mux sees values landing this cycle
    if (take && !hwrite) begin
      if (addr_index(haddr) == input_config_index) begin
        hrdata_d = {24'h00_0000, cfg_d};
      end else if (addr_index(haddr) == mux_control_index) begin
        hrdata_d = {24'h00_0000, ctrl_d & mux_control_mask};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_index_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_index_q <= wr_index_d;
      hrdata_q <= hrdata_d;
    end
  end

  // ==========================================================
  // register writes and conversion sequencing
  logic running;
  logic ctrl_wr;
  logic cfg_wr;
  logic want_conv;

  always_comb begin
    running = (state_q != conv_idle);
    ctrl_wr = wr_pend_q && (wr_index_q == mux_control_index);
    cfg_wr = wr_pend_q && (wr_index_q == input_config_index);
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    if (cfg_wr && !running) begin
      cfg_d = hwdata[7:0];
    end
    // completion clears single request before any new write lands
    if (state_q == conv_running && conv_done) begin
      ctrl_d[single_bit] = 1'b0;
    end
    if (ctrl_wr) begin
      ctrl_d[single_bit] = hwdata[single_bit];
      ctrl_d[continuous_bit] = hwdata[continuous_bit];
      if (!running) begin
        ctrl_d[channel_msb:channel_lsb] = hwdata[channel_msb:channel_lsb];
      end
    end
    ctrl_d = ctrl_d & mux_control_mask;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= reg_reset_value;
      cfg_q <= reg_reset_value;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // conversion sequencer
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    want_conv = ctrl_q[single_bit] || ctrl_q[continuous_bit];
    case (state_q)
      conv_idle: begin
        if (want_conv) begin
          state_d = conv_launch;
          start_d = 1'b1;
        end
      end
      conv_launch: begin
        state_d = conv_running;
      end
      conv_running: begin
        if (conv_done) begin
          if (ctrl_q[continuous_bit]) begin
            state_d = conv_launch;
            start_d = 1'b1;
          end else begin
            state_d = conv_idle;
          end
        end
      end
      default: begin
        state_d = conv_idle;
      end
    endcase
    busy_d = (state_d != conv_idle);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= conv_idle;
      start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      busy_q <= busy_d;
    end
  end

  // ==========================================================
  // analog path set-up from channel and input config
  adc_channel_decode u_decode (
    .channel(ctrl_d[channel_msb:channel_lsb]),
    .input_config(cfg_d),
    .kind(kind_c),
    .ref_sel(ref_c)
  );

  always_comb begin
    kind_d = kind_c;
    ref_d = ref_c;
    temp_en_d = {cfg_d[temp4_bit], cfg_d[temp3_bit]};
    pos_sw_d = cfg_d[pos_switch_bit];
    neg_sw_d = cfg_d[neg_switch_bit];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kind_q <= meas_ratiometric;
      ref_q <= ref_sensor_pins;
      temp_en_q <= 2'b00;
      pos_sw_q <= 1'b0;
      neg_sw_q <= 1'b0;
    end else begin
      kind_q <= kind_d;
      ref_q <= ref_d;
      temp_en_q <= temp_en_d;
      pos_sw_q <= pos_sw_d;
      neg_sw_q <= neg_sw_d;
    end
  end

  // ==========================================================
  // bus response, zero wait and always OKAY
  always_comb begin
    hreadyout_d = 1'b1;
    hresp_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign conv_start = start_q;
  assign conv_busy = busy_q;
  assign channel_select = ctrl_q[channel_msb:channel_lsb];
  assign meas_kind = kind_q;
  assign ref_sel = ref_q;
  assign input_temperature_enable = temp_en_q;
  assign pos_supply_switch = pos_sw_q;
  assign neg_supply_switch = neg_sw_q;

endmodule // adc_mux_control

//--- verification/adc_mux_control_properties.sv
// Purpose: port properties of the mux and start control
// Assumes: zero wait bus, one conv_done per conversion
// Notes: bound to every instance below
`timescale 1ns/1ps
module adc_mux_control_checker
  import adc_mux_pkg::*;
(
  // bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // converter side
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic [4:0] channel_select,
  input wire meas_kind_t meas_kind,
  input wire ref_sel_t ref_sel
);
  logic wr_d;
  logic wr_q;
  logic rd_d;
  logic rd_q;
  assign wr_d = hsel && hready && htrans[1] && hwrite && haddr == mux_control_addr;
  assign rd_d = hsel && hready && htrans[1] && !hwrite && haddr == mux_control_addr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // properties
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_start_busy; conv_start |-> conv_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not busy");
  property p_busy_rise; $rose(conv_busy) |-> conv_start; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
  property p_done_next; conv_busy && !conv_start && conv_done |=> conv_start || !conv_busy;
  endproperty
  a_done_next: assert property (p_done_next) else $error("no restart or idle");
  property p_lock; conv_busy |=> $stable(channel_select); endproperty
  a_lock: assert property (p_lock) else $error("channel moved while busy");
  property p_chan_wr; wr_q && !conv_busy |=> channel_select == $past(hwdata[4:0]); endproperty
  a_chan_wr: assert property (p_chan_wr) else $error("channel not written");
  property p_reset; $rose(hresetn) |-> !conv_busy && !conv_start && channel_select == 5'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle after reset");
  property p_upper; hrdata[31:8] == 24'h00_0000 && !(rd_q && hrdata[7]); endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_current; channel_select >= ch_bridge_first && channel_select <= ch_switch_last
    |-> meas_kind == meas_current && ref_sel == ref_internal_current; endproperty
  a_current: assert property (p_current) else $error("current path wrong");
  property p_supply; channel_select == ch_main_supply
    |-> meas_kind == meas_abs_voltage && ref_sel == ref_internal_voltage; endproperty
  a_supply: assert property (p_supply) else $error("supply path wrong");
  c_restart: cover property (conv_busy && conv_done ##1 conv_start);
  c_locked_wr: cover property (wr_q && conv_busy);
  c_finish: cover property ($fell(conv_busy));
endmodule // adc_mux_control_checker

bind adc_mux_control adc_mux_control_checker chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .conv_done(conv_done), .conv_start(conv_start),
  .conv_busy(conv_busy), .channel_select(channel_select), .meas_kind(meas_kind),
  .ref_sel(ref_sel));

//--- verification/tb.sv
// Purpose: self-checking bench for the mux and start control
// Assumes: zero wait bus, the core is played by conv_done pulses
// Notes: register images kept as integers
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %0h want %0h", $time, a, e); end end
module tb;
  import adc_mux_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_done, conv_start, conv_busy;
  logic pos_sw, neg_sw;
  logic [1:0] htrans, temp_en;
  logic [2:0] hsize;
  logic [4:0] chan;
  logic [31:0] haddr, hwdata, hrdata, r;
  meas_kind_t kind;
  ref_sel_t rsel;
  wire hready = hreadyout;
  int n_mismatch, num_checks, n_start, ctrl_m, cfg_m, busy_m, s, e, k;
  integer seed = 32'h9578;
  int eref[8] = '{0, 1, 2, 1, -1, -1, -1, 3};
  adc_mux_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
    .conv_start(conv_start), .conv_busy(conv_busy), .channel_select(chan),
    .meas_kind(kind), .ref_sel(rsel), .input_temperature_enable(temp_en),
    .pos_supply_switch(pos_sw), .neg_supply_switch(neg_sw));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (conv_start === 1'b1) n_start <= n_start + 1;
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end
  // ==========================================================
  // bus and model
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= htrans_nonseq;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : $random(seed);
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input int d);
    bus(a, 1'b1, d);
    if (a == mux_control_addr) ctrl_m = busy_m ? (ctrl_m & 8'h1F) | (d & 8'h60) : d & 8'h7F;
    if (a == input_config_addr && !busy_m) cfg_m = d & 8'hFF;
    busy_m = busy_m || (ctrl_m & 8'h60) != 0;
  endtask
  task automatic rd(input logic [31:0] a);
    bus(a, 1'b0, 32'h0);
    e = a == mux_control_addr ? ctrl_m : a == input_config_addr ? cfg_m : 0;
    `CHK(r, e)
  endtask
  task automatic done;
    conv_done <= 1'b1;
    @(posedge hclk);
    conv_done <= 1'b0;
    ctrl_m = ctrl_m & 8'h5F;
    busy_m = (ctrl_m & 8'h40) != 0;
    @(posedge hclk);
    #1;
  endtask
  task automatic chk_dec(input int c);
    k = c < 4 ? (c > 1 && cfg_m[c + 2] ? 3 : cfg_m[c]) : c < 16 ? 2 : c == 17 ? 4 : -1;
    if (c == 16 || c == 18) k = 1;
    if (c > 18 && c < 25) k = 7;
    if (c == 25 || c == 26) k = 0;
    if (c > 26) k = c == 31 ? 2 : 1;
    `CHK(chan, c[4:0])
    if (k >= 0) `CHK(kind, k)
    if (k >= 0 && eref[k] >= 0) `CHK(rsel, eref[k])
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_done = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(mux_control_addr);
    rd(input_config_addr);
    rd(32'h0000004C);
    `CHK({hreadyout, hresp, conv_busy, chan}, 8'h80)
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      wr(input_config_addr, p == 0 ? 0 : ($random(seed) & 8'hCF) | (p == 1 ? 8'h10 : 8'h20));
      `CHK({pos_sw, neg_sw, temp_en}, cfg_m[7:4])
      for (int c = 0; c < 32; c++) begin
        wr(mux_control_addr, ($random(seed) & 8'h80) | c);
        rd(mux_control_addr);
        chk_dec(c);
      end
    end
    $display("test decode done");
    done;
    s = n_start;
    wr(mux_control_addr, 8'h2B);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(n_start, s + 1)
    `CHK(conv_busy, 1'b1)
    wr(mux_control_addr, 8'h25);
    wr(input_config_addr, 8'hAA);
    rd(mux_control_addr);
    rd(input_config_addr);
    done;
    `CHK(conv_busy, 1'b0)
    rd(mux_control_addr);
    $display("test single done");
    wr(mux_control_addr, 8'h70);
    for (int i = 0; i < 2; i++) begin
      repeat (2) @(posedge hclk);
      #1;
      done;
      rd(mux_control_addr);
    end
    `CHK(n_start, s + 4)
    wr(mux_control_addr, 8'h00);
    done;
    `CHK(conv_busy, 1'b0)
    `CHK(n_start, s + 4)
    rd(mux_control_addr);
    $display("test continuous done");
    wr(mux_control_addr, 8'h47);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    ctrl_m = 0;
    cfg_m = 0;
    busy_m = 0;
    @(posedge hclk);
    #1;
    `CHK({conv_busy, conv_start, chan}, 7'h00)
    rd(mux_control_addr);
    rd(input_config_addr);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // tb
